// File: servo_move_regs.svh
// Purpose: register offsets, command bit positions and reset values
// Assumes: 32-bit AXI4-Lite word per register, byte addresses below
// Notes: definitions only
`ifndef SERVO_MOVE_REGS_SVH
`define SERVO_MOVE_REGS_SVH
`define ADDR_W 8
`define OFS_CMD_LO 8'h00
`define OFS_CMD_HI 8'h04
`define OFS_RSP_LO 8'h08
`define OFS_RSP_HI 8'h0C
`define OFS_FEED_UNIT 8'h10
`define OFS_ORIGIN_MODE 8'h14
`define OFS_MAX_SPEED 8'h18
`define OFS_FEED_SPEED 8'h1C
`define OFS_STEP_BASE 8'h20
`define STEP_COUNT 4
`define BIT_CSTRT 0
`define BIT_CODE_LSB 8
`define BIT_CODE_MSB 11
`define BIT_CANCEL 16
`define BIT_HOLD 17
`define BIT_MANUAL 19
`define BIT_STEP 20
`define BIT_STATION 21
`define BIT_TABLE 22
`define BIT_ORIGIN 23
`define BIT_REL 24
`define BIT_DIR 25
`define OVR_NONE 8'h64
`define OVR_MAX 8'hC8
`define CODE_NOP 4'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RST_WORD 32'h0000_0000
`define RST_FEED_SPEED 32'h0000_03E8
`define RST_MAX_SPEED 32'h0000_0BB8
`endif

// File: servo_move_pkg.sv
// Purpose: shared types of the move command handler
// Assumes: nothing beyond SystemVerilog packages
// Notes: states are Gray along idle, run, hold, stop
package servo_move_pkg;
   typedef enum logic [1:0] {
      S_IDLE = 2'h0,
      S_RUN = 2'h1,
      S_HOLD = 2'h3,
      S_STOP = 2'h2
   } move_state_t;
   typedef enum logic [2:0] {
      K_NONE = 3'h0,
      K_MANUAL = 3'h1,
      K_STEP = 3'h2,
      K_STATION = 3'h3,
      K_TABLE = 3'h4,
      K_ORIGIN = 3'h5,
      K_POSITION = 3'h6
   } move_kind_t;
endpackage

// File: servo_move_command_handler.sv
// Purpose: interpret move command frames, drive motion, build status
// Assumes: each write to the low command word is one received frame
// Notes: write the command data word before the low command word
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "servo_move_regs.svh"

module servo_move_command_handler
   import servo_move_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic unit_ready,
   input wire logic main_power_on,
   input wire logic estop_active,
   input wire logic alarm_active,
   input wire logic warning_active,
   input wire logic servo_on_status,
   input wire logic motion_done,
   input wire logic axis_stopped,
   input wire logic origin_range,
   input wire logic near_range,
   input wire logic in_position,
   input wire logic neg_limit,
   input wire logic pos_limit,
   input wire logic [31:0] response_data,
   output logic motion_enable,
   output logic decel_stop,
   output move_kind_t move_kind,
   output logic move_dir,
   output logic move_relative,
   output logic [31:0] move_speed,
   output logic [31:0] move_target,
   output logic [3:0] move_code,
   output logic [7:0] origin_mode,
   output logic progressing_flag,
   output logic holding_flag,
   output logic manual_feed_echo
);

   logic aw_held;
   logic [7:0] aw_addr_q;
   logic w_held;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_fire;
   logic wr_ok;
   logic frame_strobe;
   logic [31:0] cmd_lo;
   logic [31:0] cmd_hi;
   logic [31:0] new_cmd;
   logic [31:0] rise;
   logic [31:0] fall;
   logic feed_unit_select_param;
   logic [31:0] max_speed;
   logic [31:0] feed_speed;
   logic [31:0] step_dist [`STEP_COUNT];
   move_state_t state;
   move_state_t next_state;
   move_kind_t start_kind;
   logic active_fall;
   logic cancel_now;
   logic hold_rise;
   logic hold_fall;
   logic [7:0] override_pct;
   logic [39:0] scaled_speed;
   logic [31:0] manual_speed;
   logic [31:0] rsp_lo;
   logic [31:0] rsp_hi;
   logic [31:0] read_word;
   logic read_ok;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                               input logic [31:0] new_word,
                                               input logic [3:0] lanes);
      logic [31:0] result;
      result = old_word;
      for (int i = 0; i < 4; i++)
      begin
         if (lanes[i])
         begin
            result[i*8 +: 8] = new_word[i*8 +: 8];
         end
      end
      return result;
   endfunction

   // Write channel: address and data taken in either order
   assign awready = !aw_held && !bvalid;
   assign wready = !w_held && !bvalid;
   assign wr_fire = aw_held && w_held && !bvalid;
   assign frame_strobe = wr_fire && (aw_addr_q == `OFS_CMD_LO);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         aw_addr_q <= 8'h00;
      end
      else if (awvalid && awready)
      begin
         aw_held <= 1'b1;
         aw_addr_q <= awaddr;
      end
      else if (wr_fire)
      begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held <= 1'b0;
         wdata_q <= `RST_WORD;
         wstrb_q <= 4'h0;
      end
      else if (wvalid && wready)
      begin
         w_held <= 1'b1;
         wdata_q <= wdata;
         wstrb_q <= wstrb;
      end
      else if (wr_fire)
      begin
         w_held <= 1'b0;
      end
   end

   always_comb
   begin
      case (aw_addr_q)
         `OFS_CMD_LO, `OFS_CMD_HI, `OFS_RSP_LO, `OFS_RSP_HI: wr_ok = 1'b1;
         `OFS_FEED_UNIT, `OFS_ORIGIN_MODE, `OFS_MAX_SPEED: wr_ok = 1'b1;
         `OFS_FEED_SPEED: wr_ok = 1'b1;
         default: wr_ok = (aw_addr_q[7:4] == 4'(`OFS_STEP_BASE >> 4))
                          && !aw_addr_q[1] && !aw_addr_q[0];
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid <= 1'b1;
         bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bready)
      begin
         bvalid <= 1'b0;
      end
   end

   // Frame words; the low word arriving marks one received frame
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cmd_lo <= `RST_WORD;
         cmd_hi <= `RST_WORD;
      end
      else if (wr_fire)
      begin
         if (aw_addr_q == `OFS_CMD_LO)
         begin
            cmd_lo <= new_cmd;
         end
         if (aw_addr_q == `OFS_CMD_HI)
         begin
            cmd_hi <= merge_bytes(cmd_hi, wdata_q, wstrb_q);
         end
      end
   end

   // Settings registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         feed_unit_select_param <= 1'b0;
         origin_mode <= 8'h00;
         max_speed <= `RST_MAX_SPEED;
         feed_speed <= `RST_FEED_SPEED;
      end
      else if (wr_fire)
      begin
         if (aw_addr_q == `OFS_FEED_UNIT && wstrb_q[0])
         begin
            feed_unit_select_param <= wdata_q[0];
         end
         if (aw_addr_q == `OFS_ORIGIN_MODE && wstrb_q[0])
         begin
            origin_mode <= wdata_q[7:0];
         end
         if (aw_addr_q == `OFS_MAX_SPEED)
         begin
            max_speed <= merge_bytes(max_speed, wdata_q, wstrb_q);
         end
         if (aw_addr_q == `OFS_FEED_SPEED)
         begin
            feed_speed <= merge_bytes(feed_speed, wdata_q, wstrb_q);
         end
      end
   end

   for (genvar g = 0; g < `STEP_COUNT; g++)
   begin : gen_step
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            step_dist[g] <= `RST_WORD;
         end
         else if (wr_fire && aw_addr_q == 8'(`OFS_STEP_BASE + 4 * g))
         begin
            step_dist[g] <= merge_bytes(step_dist[g], wdata_q, wstrb_q);
         end
      end
   end

   // Edges are taken against the frame held before this one
   always_comb
   begin
      new_cmd = merge_bytes(cmd_lo, wdata_q, wstrb_q);
      rise = frame_strobe ? (new_cmd & ~cmd_lo) : `RST_WORD;
      fall = frame_strobe ? (~new_cmd & cmd_lo) : `RST_WORD;
      cancel_now = frame_strobe && new_cmd[`BIT_CANCEL];
      hold_rise = rise[`BIT_HOLD];
      hold_fall = fall[`BIT_HOLD];
   end

   always_comb
   begin
      if (rise[`BIT_MANUAL])
         start_kind = K_MANUAL;
      else if (rise[`BIT_STEP])
         start_kind = K_STEP;
      else if (rise[`BIT_STATION])
         start_kind = K_STATION;
      else if (rise[`BIT_TABLE])
         start_kind = K_TABLE;
      else if (rise[`BIT_ORIGIN])
         start_kind = K_ORIGIN;
      else if (rise[`BIT_CSTRT] && new_cmd[`BIT_CODE_MSB:`BIT_CODE_LSB] != `CODE_NOP)
         start_kind = K_POSITION;
      else
         start_kind = K_NONE;
   end

   // Positioning has no level bit of its own, so only cancel ends it early
   always_comb
   begin
      case (move_kind)
         K_MANUAL: active_fall = fall[`BIT_MANUAL];
         K_STEP: active_fall = fall[`BIT_STEP];
         K_STATION: active_fall = fall[`BIT_STATION];
         K_TABLE: active_fall = fall[`BIT_TABLE];
         K_ORIGIN: active_fall = fall[`BIT_ORIGIN];
         default: active_fall = 1'b0;
      endcase
   end

   always_comb
   begin
      next_state = state;
      case (state)
         S_IDLE:
         begin
            if (start_kind != K_NONE && servo_on_status && !new_cmd[`BIT_CANCEL])
               next_state = S_RUN;
         end
         S_RUN:
         begin
            if (cancel_now || active_fall)
               next_state = S_STOP;
            else if (hold_rise)
               next_state = S_HOLD;
            else if (motion_done && move_kind != K_MANUAL)
               next_state = S_IDLE;
         end
         S_HOLD:
         begin
            if (cancel_now || active_fall)
               next_state = S_STOP;
            else if (hold_fall)
               next_state = S_RUN;
         end
         S_STOP:
         begin
            if (axis_stopped)
               next_state = S_IDLE;
         end
         default: next_state = S_IDLE;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         state <= S_IDLE;
      else
         state <= next_state;
   end

   // Speed for manual feed: override or direct, then capped
   always_comb
   begin
      override_pct = (cmd_hi[7:0] > `OVR_MAX) ? `OVR_MAX : cmd_hi[7:0];
      scaled_speed = (40'(feed_speed) * 40'(override_pct)) / 40'(`OVR_NONE);
      if (feed_unit_select_param)
         manual_speed = cmd_hi;
      else
         manual_speed = scaled_speed[31:0];
      if (manual_speed > max_speed || (!feed_unit_select_param && |scaled_speed[39:32]))
         manual_speed = max_speed;
   end

   // Move parameters are frozen at start so later frames cannot warp them
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         move_kind <= K_NONE;
         move_dir <= 1'b0;
         move_relative <= 1'b0;
         move_speed <= `RST_WORD;
         move_target <= `RST_WORD;
         move_code <= `CODE_NOP;
      end
      else if (state == S_IDLE && next_state == S_RUN)
      begin
         move_kind <= start_kind;
         move_code <= new_cmd[`BIT_CODE_MSB:`BIT_CODE_LSB];
         move_speed <= (start_kind == K_MANUAL) ? manual_speed : max_speed;
         case (start_kind)
            K_MANUAL, K_STEP, K_STATION: move_dir <= new_cmd[`BIT_DIR];
            default: move_dir <= 1'b0;
         endcase
         case (start_kind)
            K_STATION, K_TABLE, K_POSITION: move_relative <= new_cmd[`BIT_REL];
            K_STEP: move_relative <= 1'b1;
            default: move_relative <= 1'b0;
         endcase
         case (start_kind)
            K_STEP: move_target <= step_dist[cmd_hi[1:0]];
            K_STATION: move_target <= cmd_hi;
            K_TABLE, K_POSITION: move_target <= cmd_hi;
            K_ORIGIN: move_target <= {24'h000000, origin_mode};
            default: move_target <= `RST_WORD;
         endcase
      end
   end

   assign motion_enable = (state == S_RUN);
   assign decel_stop = (state == S_HOLD) || (state == S_STOP);

   // Status flags registered once a cycle from state and the last frame
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         progressing_flag <= 1'b0;
         holding_flag <= 1'b0;
         manual_feed_echo <= 1'b0;
      end
      else
      begin
         progressing_flag <= (next_state == S_RUN) || (next_state == S_HOLD);
         holding_flag <= frame_strobe ? new_cmd[`BIT_HOLD] : cmd_lo[`BIT_HOLD];
         manual_feed_echo <= frame_strobe ? new_cmd[`BIT_MANUAL]
                                          : cmd_lo[`BIT_MANUAL];
      end
   end

   // Response words, low word holds bytes 0 to 3
   always_comb
   begin
      rsp_lo = {pos_limit, neg_limit, in_position, near_range, origin_range, 1'b0,
                cmd_lo[`BIT_DIR], cmd_lo[`BIT_REL],
                cmd_lo[`BIT_ORIGIN:`BIT_MANUAL], 1'b0, holding_flag, progressing_flag,
                cmd_lo[15:8],
                1'b0, unit_ready, main_power_on, estop_active, alarm_active,
                warning_active, servo_on_status, cmd_lo[`BIT_CSTRT]};
      rsp_hi = response_data;
   end

   always_comb
   begin
      read_ok = 1'b1;
      read_word = `RST_WORD;
      case (araddr)
         `OFS_CMD_LO: read_word = cmd_lo;
         `OFS_CMD_HI: read_word = cmd_hi;
         `OFS_RSP_LO: read_word = rsp_lo;
         `OFS_RSP_HI: read_word = rsp_hi;
         `OFS_FEED_UNIT: read_word = {31'h0, feed_unit_select_param};
         `OFS_ORIGIN_MODE: read_word = {24'h000000, origin_mode};
         `OFS_MAX_SPEED: read_word = max_speed;
         `OFS_FEED_SPEED: read_word = feed_speed;
         default:
         begin
            if (araddr[7:4] == 4'(`OFS_STEP_BASE >> 4) && araddr[1:0] == 2'h0)
               read_word = step_dist[araddr[3:2]];
            else
               read_ok = 1'b0;
         end
      endcase
   end

   // Read channel: one read in flight, answer one cycle after address
   assign arready = !rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata <= `RST_WORD;
         rresp <= `RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rdata <= read_word;
         rresp <= read_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rready)
      begin
         rvalid <= 1'b0;
      end
   end

endmodule

// File: servo_move_sva.sv
// Purpose: port checks of the move command handler
// Assumes: full-strobe writes; a frame is a write to the low command word
// Notes: a frame is judged in the cycle its write response rises
`timescale 1ns/10ps
module servo_move_sva
   import servo_move_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [31:0] wdata,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic servo_on_status,
   input wire logic motion_enable,
   input wire logic decel_stop,
   input wire move_kind_t move_kind,
   input wire logic move_dir,
   input wire logic move_relative,
   input wire logic progressing_flag,
   input wire logic holding_flag,
   input wire logic manual_feed_echo
);
   logic [7:0] a_q;
   logic [31:0] w_q;
   logic [31:0] last_q;
   logic bv_q;
   logic fr_new;
   logic [31:0] rise;
   logic [31:0] fall;
   assign fr_new = bvalid && !bv_q && a_q == 8'h00;
   assign rise = w_q & ~last_q;
   assign fall = last_q & ~w_q;
   // Previous frame kept here, the same reference the design compares against
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         a_q <= 8'h00;
         w_q <= 32'h0;
         last_q <= 32'h0;
         bv_q <= 1'b0;
      end
      else
      begin
         if (awvalid && awready)
            a_q <= awaddr;
         if (wvalid && wready)
            w_q <= wdata;
         if (fr_new)
            last_q <= w_q;
         bv_q <= bvalid;
      end
   end
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   property p_echo;
      fr_new |-> manual_feed_echo == w_q[19];
   endproperty
   a_echo: assert property (p_echo) else $error("echo flag wrong");
   property p_man_start;
      fr_new && rise[19] && !w_q[16] && !$past(motion_enable) && !$past(decel_stop)
         && $past(servo_on_status) |-> motion_enable && move_kind == K_MANUAL
         && move_dir == w_q[25];
   endproperty
   a_man_start: assert property (p_man_start) else $error("manual start wrong");
   property p_drop;
      fr_new && $past(motion_enable) && $past(move_kind) != K_POSITION
         && w_q[23:19] == 5'h00 |-> decel_stop && !motion_enable && !progressing_flag;
   endproperty
   a_drop: assert property (p_drop) else $error("no stop");
   property p_step;
      fr_new && rise[20] && !rise[19] && !w_q[16] && !$past(motion_enable)
         && !$past(decel_stop) && $past(servo_on_status) |-> move_kind == K_STEP && move_relative;
   endproperty
   a_step: assert property (p_step) else $error("step start wrong");
   property p_cancel;
      fr_new && w_q[16] |-> !progressing_flag && !motion_enable;
   endproperty
   a_cancel: assert property (p_cancel) else $error("cancel ignored");
   property p_hold;
      fr_new && rise[17] && !w_q[16] && $past(motion_enable) && fall[23:19] == 5'h00
         |-> holding_flag && decel_stop && progressing_flag;
   endproperty
   a_hold: assert property (p_hold) else $error("hold not entered");
   property p_resume;
      fr_new && fall[17] && !w_q[16] && $past(holding_flag) && $past(decel_stop)
         && $past(progressing_flag) && fall[23:19] == 5'h00 |-> motion_enable && !holding_flag;
   endproperty
   a_resume: assert property (p_resume) else $error("no resume");
   property p_progressing_flag;
      motion_enable |-> progressing_flag;
   endproperty
   a_progressing_flag: assert property (p_progressing_flag) else $error("progressing low while moving");
   property p_once;
      fr_new && (rise & 32'h00F8_0001) == 32'h0 && !$past(motion_enable)
         && !$past(decel_stop) |-> !motion_enable;
   endproperty
   a_once: assert property (p_once) else $error("start without a rising bit");
   c_man: cover property (fr_new && rise[19] && motion_enable);
   c_hold: cover property (holding_flag && decel_stop);
   c_cancel: cover property (fr_new && w_q[16] && $past(motion_enable));
endmodule
bind servo_move_command_handler servo_move_sva u_sva (.*);

// File: drive_model.sv
// Purpose: servo drive stand-in that finishes moves and brings the axis to rest
// Assumes: a move completes after run_len cycles of motion
// Notes: deceleration takes four cycles; a large run_len gives a slow drive
`timescale 1ns/10ps
module drive_model
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic motion_enable,
   input wire logic decel_stop,
   input wire logic [7:0] run_len,
   output logic motion_done,
   output logic axis_stopped
);
   logic [7:0] run_cnt;
   logic [2:0] stop_cnt;
   // Done is raised for manual feed too; the handler must ignore it there
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         run_cnt <= 8'h00;
         stop_cnt <= 3'h0;
         motion_done <= 1'b0;
         axis_stopped <= 1'b1;
      end
      else
      begin
         run_cnt <= motion_enable ? run_cnt + 8'(run_cnt != run_len) : 8'h00;
         stop_cnt <= decel_stop ? stop_cnt + 3'(stop_cnt != 3'h4) : 3'h0;
         motion_done <= motion_enable && run_cnt == run_len;
         axis_stopped <= !motion_enable && (!decel_stop || stop_cnt == 3'h4);
      end
   end
endmodule

// File: tb_servo_move_command_handler.sv
// Purpose: self-checking bench of the move command handler
// Assumes: drive model on the motion side, bench as host on the bus
// Notes: a frame is a data word write followed by a command word write
`timescale 1ns/10ps
`include "servo_move_regs.svh"
module tb_servo_move_command_handler
   import servo_move_pkg::*;
;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0] awaddr, araddr, run_len, origin_mode;
   logic [31:0] wdata, response_data, rv, rdata, move_speed, move_target;
   logic [3:0] wstrb, move_code;
   logic [1:0] bresp, rresp, rs;
   logic unit_ready, main_power_on, estop_active, alarm_active, warning_active;
   logic servo_on_status, origin_range, near_range, in_position, neg_limit, pos_limit;
   logic awready, wready, bvalid, arready, rvalid, motion_done, axis_stopped;
   logic motion_enable, decel_stop, move_dir, move_relative;
   logic progressing_flag, holding_flag, manual_feed_echo;
   move_kind_t move_kind;
   int err_total = 0;
   int tests_run = 0;
   int cyc = 0;
   servo_move_command_handler dut (.*);
   drive_model u_drive (.*);
   task automatic finish_test;
      begin
         $display("checks %0d mismatches %0d", tests_run, err_total);
         if (err_total == 0 && tests_run > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   task automatic chk(input logic [63:0] s, input logic [63:0] e);
      begin
         tests_run++;
         if (s !== e)
         begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
         end
      end
   endtask
   // One write or one read; each valid held until its own ready
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      begin
         @(posedge aclk);
         awaddr <= a;
         araddr <= a;
         wdata <= d;
         awvalid <= w;
         wvalid <= w;
         bready <= w;
         arvalid <= !w;
         rready <= !w;
         do
         begin
            @(posedge aclk);
            if (awready)
               awvalid <= 1'b0;
            if (wready)
               wvalid <= 1'b0;
            if (arready)
               arvalid <= 1'b0;
         end
         while (!(w ? bvalid : rvalid));
         rs = w ? bresp : rresp;
         rv = rdata;
         bready <= 1'b0;
         rready <= 1'b0;
      end
   endtask
   task automatic fr(input logic [31:0] hi, input logic [31:0] lo);
      begin
         bus(1'b1, `OFS_CMD_HI, hi);
         bus(1'b1, `OFS_CMD_LO, lo);
      end
   endtask
   task automatic wait_idle;
      begin
         do
            @(posedge aclk);
         while (motion_enable || decel_stop);
      end
   endtask
   task automatic t_regs;
      begin
         bus(1'b0, `OFS_MAX_SPEED, 32'h0);
         chk(rv, `RST_MAX_SPEED);
         bus(1'b0, `OFS_FEED_SPEED, 32'h0);
         chk(rv, `RST_FEED_SPEED);
         bus(1'b0, 8'hFC, 32'h0);
         chk({rs, rv}, {`RESP_SLVERR, 32'h0});
         bus(1'b1, 8'hFC, 32'h1);
         chk(rs, `RESP_SLVERR);
         bus(1'b0, `OFS_RSP_LO, 32'h0);
         chk({rv[31:27], rv[7:1]}, {5'h0B, 7'h2B});
         bus(1'b1, `OFS_RSP_HI, 32'h0);
         bus(1'b0, `OFS_RSP_HI, 32'h0);
         chk(rv, 32'hA5C3_0F96);
         {unit_ready, main_power_on, estop_active, warning_active} <= 4'hC;
      end
   endtask
   task automatic man(input logic u, input logic [31:0] d, input logic [31:0] mx,
                      input logic [31:0] e);
      begin
         bus(1'b1, `OFS_FEED_UNIT, {31'h0, u});
         bus(1'b1, `OFS_MAX_SPEED, mx);
         fr(d, 32'h0208_0000);
         chk({move_kind, move_dir, move_speed}, {K_MANUAL, 1'h1, e});
         repeat (20) @(posedge aclk);
         chk({motion_enable, progressing_flag, manual_feed_echo}, 3'h7);
         fr(d, 32'h0);
         chk({decel_stop, motion_enable, progressing_flag, manual_feed_echo}, 4'h8);
         wait_idle;
      end
   endtask
   task automatic t_step;
      int i;
      begin
         for (i = 0; i < 4; i++)
            bus(1'b1, `OFS_STEP_BASE + 8'(4 * i), 32'h100 + i);
         for (i = 0; i < 4; i++)
         begin
            fr(i, 32'h0010_0000);
            chk({move_kind, move_relative, move_target}, {K_STEP, 1'h1, 32'h100 + i});
            wait_idle;
            chk(progressing_flag, 1'h0);
            fr(i, 32'h0010_0000);
            chk(motion_enable, 1'h0);
            fr(i, 32'h0);
         end
         run_len <= 8'hFF;
         fr(32'h0, 32'h0010_0000);
         fr(32'h0, 32'h0);
         chk({decel_stop, progressing_flag}, 2'h2);
         wait_idle;
      end
   endtask
   task automatic t_moves;
      logic [31:0] lo [4] = '{32'h0320_0000, 32'h0140_0000, 32'h0080_0000, 32'h0300_0101};
      move_kind_t k [4] = '{K_STATION, K_TABLE, K_ORIGIN, K_POSITION};
      int i;
      begin
         bus(1'b1, `OFS_ORIGIN_MODE, 32'h3);
         for (i = 0; i < 4; i++)
         begin
            fr(32'h7, lo[i]);
            chk({move_kind, move_relative}, {k[i], lo[i][24]});
            if (i == 0)
               chk(move_dir, 1'h1);
            if (i == 2)
               chk({origin_mode, move_target}, {8'h03, 32'h3});
            if (i == 3)
               chk({move_dir, move_code, move_speed}, {1'h0, 4'h1, 32'h0000_0BB8});
            fr(32'h7, (i == 3) ? 32'h0001_0000 : 32'h0);
            chk({decel_stop, progressing_flag}, 2'h2);
            wait_idle;
         end
      end
   endtask
   task automatic t_hold;
      begin
         fr(32'h5, 32'h0020_0000);
         fr(32'h5, 32'h0022_0000);
         repeat (10) @(posedge aclk);
         chk({holding_flag, decel_stop, progressing_flag}, 3'h7);
         bus(1'b0, `OFS_RSP_LO, 32'h0);
         chk({rv[23:16], rv[7:0]}, 16'h2362);
         fr(32'h5, 32'h0020_0000);
         chk({holding_flag, motion_enable}, 2'h1);
         fr(32'h5, 32'h0021_0000);
         chk({progressing_flag, motion_enable}, 2'h0);
         fr(32'h5, 32'h0);
         wait_idle;
      end
   endtask
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // Hang guard; the whole run needs well under a thousand cycles
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         finish_test;
      end
   end
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
      {awaddr, araddr, wdata} = 48'h0;
      wstrb = 4'hF;
      {unit_ready, main_power_on, estop_active, alarm_active, warning_active} = 5'h15;
      {servo_on_status, pos_limit, neg_limit, in_position, near_range, origin_range} = 6'h2B;
      response_data = 32'hA5C3_0F96;
      run_len = 8'h05;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      man(1'b0, 32'h96, 32'hBB8, 32'h5DC);
      man(1'b0, 32'hC8, 32'h640, 32'h640);
      man(1'b0, 32'hFA, 32'hBB8, 32'h7D0);
      man(1'b0, 32'h64, 32'hBB8, 32'h3E8);
      man(1'b1, 32'h50, 32'hBB8, 32'h50);
      servo_on_status <= 1'b0;
      fr(32'h64, 32'h0008_0000);
      chk({manual_feed_echo, progressing_flag, motion_enable}, 3'h4);
      servo_on_status <= 1'b1;
      fr(32'h64, 32'h0);
      t_step;
      t_moves;
      t_hold;
      finish_test;
   end
endmodule
